/* File: hdl/cfgl_loader.sv */
/*
 * Configuration preset word loader top: fetches preset words after reset,
 * places them into per-function and per-port configuration fields and
 * serves those fields to software as an APB slave.
 * Assumes an APB master on pclk and a preset memory with a req/ack port.
 */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - word 4Ch low byte is function 2 revision, high byte its interface byte.
// - word 4Eh becomes host port 1 phy control, shared by all functions.
// - word 5Eh becomes host port 2 phy control, shared by all functions.
// - bit 0 of words 50h..56h is each port's no-soft-reset flag, bit 3.
// - bits 3..1 of the port word fill auxiliary current, capability bits 24..22.
// - bit 4 of the port word sets read-only D1 support, capability bit 25.
// - bit 5 of the port word sets read-only D2 support, capability bit 26.
// - bits 7..6 of the port word fill wake-event support, capability bits 29..28.
// - bytes 51h..57h fill each port's read-only data byte, control bits 31..24.
// - words 58h..5Ch give each function's sub-class and base-class bytes.
module cfgl_loader (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// preset memory
	input  wire logic        mem_present,
	output logic             mem_req,
	output logic [7:0]       mem_addr,
	input  wire logic [15:0] mem_rdata,
	input  wire logic        mem_ack,
	// loaded settings to the rest of the chip
	output logic [15:0]      phy1_ctrl,
	output logic [15:0]      phy2_ctrl,
	output logic [3:0]       no_soft_reset,
	output logic             load_done
);
	logic             word_valid;
	logic [7:0]       word_addr;
	logic [15:0]      word_data;
	logic             preset_absent;
	logic [3:0][31:0] pm_cap;
	logic [3:0][31:0] pm_ctl;

	logic [15:0]      phy1_reg;
	logic [15:0]      phy2_reg;
	logic [7:0]       f2_rev_reg;
	logic [7:0]       f2_progif_reg;
	logic [2:0][15:0] class_reg;
	logic [2:0][31:0] class_rev;

	logic             pready_reg;
	logic [31:0]      prdata_reg;
	logic             pslverr_reg;

	cfgl_fetch u_fetch (
		.pclk          (pclk),
		.presetn       (presetn),
		.mem_present   (mem_present),
		.mem_req       (mem_req),
		.mem_addr      (mem_addr),
		.mem_rdata     (mem_rdata),
		.mem_ack       (mem_ack),
		.word_valid    (word_valid),
		.word_addr     (word_addr),
		.word_data     (word_data),
		.load_done     (load_done),
		.preset_absent (preset_absent)
	);

	// address decode
	wire [3:0] idx      = paddr[cfgl_pkg::IDX_MSB:cfgl_pkg::IDX_LSB];
	wire [7:0] off      = paddr[7:0];
	wire       is_func  = (idx < 4'(cfgl_pkg::NUM_FUNC));
	wire       is_port  = (idx < 4'(cfgl_pkg::NUM_PORT));
	wire       hit_cls  = (off == cfgl_pkg::OFF_CLASS_REV) && is_func;
	wire       hit_cap  = (off == cfgl_pkg::OFF_PM_CAP) && is_port;
	wire       hit_ctl  = (off == cfgl_pkg::OFF_PM_CTL) && is_port;
	wire       hit_phy1 = (off == cfgl_pkg::OFF_PHY1) && is_func;
	wire       hit_phy2 = (off == cfgl_pkg::OFF_PHY2) && is_func;
	wire       hit_stat = (off == cfgl_pkg::OFF_LOAD_STAT) && (idx == 4'h0);
	wire       mapped   = hit_cls | hit_cap | hit_ctl | hit_phy1 | hit_phy2 | hit_stat;
	wire [1:0] pidx     = idx[1:0];

	// access phase answered one cycle late, and only once loading is over
	wire       answer   = psel && penable && !pready_reg && load_done;
	wire       wr_fire  = psel && penable && pready_reg && pwrite && mapped;
	wire [3:0] ctl_sel  = (wr_fire && hit_ctl) ? (4'h1 << pidx) : 4'h0;

	// loaded word decode
	wire ld_f2rev = word_valid && (word_addr == cfgl_pkg::PW_F2_REV);
	wire ld_phy1  = word_valid && (word_addr == cfgl_pkg::PW_PHY1);
	wire ld_phy2  = word_valid && (word_addr == cfgl_pkg::PW_PHY2);

	cfgl_port_regs u_ports (
		.pclk          (pclk),
		.presetn       (presetn),
		.word_valid    (word_valid),
		.word_addr     (word_addr),
		.word_data     (word_data),
		.wr_sel        (ctl_sel),
		.wr_data       (pwdata),
		.wr_lane0      (pstrb[0]),
		.wr_lane1      (pstrb[1]),
		.pm_cap        (pm_cap),
		.pm_ctl        (pm_ctl),
		.no_soft_reset (no_soft_reset)
	);

	// per-function class and revision registers
	genvar f;
	generate
		for (f = 0; f < cfgl_pkg::NUM_FUNC; f = f + 1) begin : g_func
			wire ld_cls = word_valid &&
				(word_addr == 8'(cfgl_pkg::PW_FUNC0_CLASS + 8'(2 * f)));

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					class_reg[f] <= {cfgl_pkg::DEF_BASECLASS, cfgl_pkg::DEF_SUBCLASS};
				else if (ld_cls)
					class_reg[f] <= word_data;
			end

			// functions 0 and 1 keep built-in revision and interface bytes
			if (f == 2) begin : g_f2
				assign class_rev[f] = {class_reg[f], f2_progif_reg, f2_rev_reg};
			end else begin : g_fx
				assign class_rev[f] = {class_reg[f], cfgl_pkg::DEF_PROGIF,
					cfgl_pkg::DEF_REVISION};
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			f2_rev_reg    <= cfgl_pkg::DEF_REVISION;
			f2_progif_reg <= cfgl_pkg::DEF_PROGIF;
		end else if (ld_f2rev) begin
			f2_rev_reg    <= word_data[7:0];
			f2_progif_reg <= word_data[15:8];
		end
	end

	// phy control: preset load, then software may rewrite it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phy1_reg <= cfgl_pkg::DEF_PHY;
			phy2_reg <= cfgl_pkg::DEF_PHY;
		end else begin
			if (ld_phy1)
				phy1_reg <= word_data;
			else if (wr_fire && hit_phy1) begin
				if (pstrb[0])
					phy1_reg[7:0] <= pwdata[7:0];
				if (pstrb[1])
					phy1_reg[15:8] <= pwdata[15:8];
			end
			if (ld_phy2)
				phy2_reg <= word_data;
			else if (wr_fire && hit_phy2) begin
				if (pstrb[0])
					phy2_reg[7:0] <= pwdata[7:0];
				if (pstrb[1])
					phy2_reg[15:8] <= pwdata[15:8];
			end
		end
	end

	// read selection
	wire [31:0] stat_word = {30'h0000_0000, preset_absent, load_done};
	wire [31:0] rd_mux =
		hit_cls  ? class_rev[idx[1:0] == 2'h3 ? 2'h0 : idx[1:0]] :
		hit_cap  ? pm_cap[pidx] :
		hit_ctl  ? pm_ctl[pidx] :
		hit_phy1 ? {16'h0000, phy1_reg} :
		hit_phy2 ? {16'h0000, phy2_reg} :
		hit_stat ? stat_word : 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg  <= answer;
			pslverr_reg <= answer && !mapped;
			if (answer)
				prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
		end
	end

	assign pready    = pready_reg;
	assign prdata    = prdata_reg;
	assign pslverr   = pslverr_reg;
	assign phy1_ctrl = phy1_reg;
	assign phy2_ctrl = phy2_reg;
endmodule
`default_nettype wire

/* File: hdl/cfgl_pkg.sv */
/*
 * Constants for the configuration preset word loader: register offsets,
 * preset word addresses, field positions and built-in defaults.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cfgl_pkg;

	// counts
	localparam int NUM_FUNC = 3;
	localparam int NUM_PORT = 4;

	// register byte offsets within one function or port window
	localparam logic [7:0] OFF_CLASS_REV = 8'h08;
	localparam logic [7:0] OFF_PM_CAP    = 8'h80;
	localparam logic [7:0] OFF_PM_CTL    = 8'h84;
	localparam logic [7:0] OFF_PHY1      = 8'hA0;
	localparam logic [7:0] OFF_PHY2      = 8'hA4;
	localparam logic [7:0] OFF_LOAD_STAT = 8'hF0;

	// paddr[11:8] selects the function or port window
	localparam int IDX_MSB = 11;
	localparam int IDX_LSB = 8;

	// preset word addresses
	localparam logic [7:0] PW_F2_REV      = 8'h4C;
	localparam logic [7:0] PW_PHY1        = 8'h4E;
	localparam logic [7:0] PW_PORT0       = 8'h50;
	localparam logic [7:0] PW_FUNC0_CLASS = 8'h58;
	localparam logic [7:0] PW_PHY2        = 8'h5E;
	localparam logic [7:0] PW_FIRST       = 8'h4C;
	localparam logic [7:0] PW_LAST        = 8'h5E;
	localparam logic [7:0] PW_STEP        = 8'h02;

	// fields within a port preset word
	localparam int PW_NSR_BIT  = 0;
	localparam int PW_AUX_LSB  = 1;
	localparam int PW_D1_BIT   = 4;
	localparam int PW_D2_BIT   = 5;
	localparam int PW_WAKE_LSB = 6;
	localparam int PW_DATA_LSB = 8;

	// fields within the registers
	localparam int CLS_PROGIF_LSB = 8;
	localparam int CLS_SUB_LSB    = 16;
	localparam int CLS_BASE_LSB   = 24;
	localparam int PMCAP_AUX_LSB  = 22;
	localparam int PMCAP_D1_BIT   = 25;
	localparam int PMCAP_D2_BIT   = 26;
	localparam int PMCAP_WAKE_LSB = 28;
	localparam int PMCTL_NSR_BIT  = 3;
	localparam int PMCTL_PME_BIT  = 8;
	localparam int PMCTL_DATA_LSB = 24;
	localparam int STAT_DONE_BIT   = 0;
	localparam int STAT_ABSENT_BIT = 1;

	// built-in defaults kept when no preset memory is present
	localparam logic [7:0]  DEF_REVISION  = 8'h00;
	localparam logic [7:0]  DEF_PROGIF    = 8'h20;
	localparam logic [7:0]  DEF_SUBCLASS  = 8'h03;
	localparam logic [7:0]  DEF_BASECLASS = 8'h0C;
	localparam logic [15:0] DEF_PHY       = 16'h0000;
	localparam logic [15:0] DEF_PORT_WORD = 16'h0000;
	localparam logic [15:0] PMCAP_LOW     = 16'h0001;

endpackage

/* File: hdl/cfgl_fetch.sv */
/*
 * Fetch engine: after reset walks the preset word addresses from first to
 * last, one request per word, and presents each word as a one-cycle pulse.
 * Assumes the preset memory answers with a one-cycle mem_ack; mem_req and mem_addr are held until it.
 */
`timescale 1ns/1ps
`default_nettype none
module cfgl_fetch (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// preset memory
	input  wire logic        mem_present,
	output logic             mem_req,
	output logic [7:0]       mem_addr,
	input  wire logic [15:0] mem_rdata,
	input  wire logic        mem_ack,
	// loaded words
	output logic             word_valid,
	output logic [7:0]       word_addr,
	output logic [15:0]      word_data,
	output logic             load_done,
	output logic             preset_absent
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_REQ  = 3'b010,
		ST_DONE = 3'b100
	} cfgl_fetch_st_t;

	cfgl_fetch_st_t state_reg, state_next;
	logic [7:0]     addr_reg;
	logic           valid_reg;
	logic [7:0]     waddr_reg;
	logic [15:0]    wdata_reg;
	logic           done_reg;
	logic           absent_reg;

	wire take = (state_reg == ST_REQ) && mem_ack;
	wire last = (addr_reg == cfgl_pkg::PW_LAST);

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: state_next = mem_present ? ST_REQ : ST_DONE;
			ST_REQ:  state_next = (take && last) ? ST_DONE : ST_REQ;
			ST_DONE: state_next = ST_DONE;
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg  <= ST_IDLE;
			addr_reg   <= cfgl_pkg::PW_FIRST;
			valid_reg  <= 1'b0;
			waddr_reg  <= 8'h00;
			wdata_reg  <= 16'h0000;
			done_reg   <= 1'b0;
			absent_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			valid_reg <= take;
			if (take) begin
				waddr_reg <= addr_reg;
				wdata_reg <= mem_rdata;
				addr_reg  <= addr_reg + cfgl_pkg::PW_STEP;
			end
			if (state_reg == ST_IDLE && !mem_present)
				absent_reg <= 1'b1;
			// one cycle after the last word so its fields are settled
			done_reg <= (state_reg == ST_DONE);
		end
	end

	assign mem_req       = (state_reg == ST_REQ);
	assign mem_addr      = addr_reg;
	assign word_valid    = valid_reg;
	assign word_addr     = waddr_reg;
	assign word_data     = wdata_reg;
	assign load_done     = done_reg;
	assign preset_absent = absent_reg;
endmodule
`default_nettype wire

/* File: hdl/cfgl_port_regs.sv */
/*
 * Power-management capability and control/data registers for ports 0..3,
 * filled from the port preset words and partly writable by software.
 * Assumes word_valid is a one-cycle pulse and wr_sel a one-cycle strobe.
 */
`timescale 1ns/1ps
`default_nettype none
module cfgl_port_regs (
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// loaded words
	input  wire logic              word_valid,
	input  wire logic [7:0]        word_addr,
	input  wire logic [15:0]       word_data,
	// software write to the control register
	input  wire logic [3:0]        wr_sel,
	input  wire logic [31:0]       wr_data,
	input  wire logic              wr_lane0,
	input  wire logic              wr_lane1,
	// register images
	output logic [3:0][31:0]       pm_cap,
	output logic [3:0][31:0]       pm_ctl,
	output logic [3:0]             no_soft_reset
);
	genvar p;
	generate
		for (p = 0; p < cfgl_pkg::NUM_PORT; p = p + 1) begin : g_port
			logic [15:0] word_reg;
			logic [1:0]  pstate_reg;
			logic        pme_en_reg;
			wire         hit = word_valid &&
				(word_addr == 8'(cfgl_pkg::PW_PORT0 + 8'(2 * p)));

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					word_reg   <= cfgl_pkg::DEF_PORT_WORD;
					pstate_reg <= 2'h0;
					pme_en_reg <= 1'b0;
				end else begin
					if (hit)
						word_reg <= word_data;
					// only state and wake enable are writable
					if (wr_sel[p] && wr_lane0)
						pstate_reg <= wr_data[1:0];
					if (wr_sel[p] && wr_lane1)
						pme_en_reg <= wr_data[cfgl_pkg::PMCTL_PME_BIT];
				end
			end

			always_comb begin
				pm_cap[p] = {16'h0000, cfgl_pkg::PMCAP_LOW};
				pm_cap[p][cfgl_pkg::PMCAP_AUX_LSB +: 3] =
					word_reg[cfgl_pkg::PW_AUX_LSB +: 3];
				pm_cap[p][cfgl_pkg::PMCAP_D1_BIT] =
					word_reg[cfgl_pkg::PW_D1_BIT];
				pm_cap[p][cfgl_pkg::PMCAP_D2_BIT] =
					word_reg[cfgl_pkg::PW_D2_BIT];
				pm_cap[p][cfgl_pkg::PMCAP_WAKE_LSB +: 2] =
					word_reg[cfgl_pkg::PW_WAKE_LSB +: 2];
				pm_ctl[p] = 32'h0000_0000;
				pm_ctl[p][1:0] = pstate_reg;
				pm_ctl[p][cfgl_pkg::PMCTL_NSR_BIT] =
					word_reg[cfgl_pkg::PW_NSR_BIT];
				pm_ctl[p][cfgl_pkg::PMCTL_PME_BIT] = pme_en_reg;
				pm_ctl[p][cfgl_pkg::PMCTL_DATA_LSB +: 8] =
					word_reg[cfgl_pkg::PW_DATA_LSB +: 8];
			end

			assign no_soft_reset[p] = word_reg[cfgl_pkg::PW_NSR_BIT];
		end
	endgenerate
endmodule
`default_nettype wire

/* File: sim/cfgl_mem_model.sv */
/* preset memory model: one-cycle ack after 0 or 3 wait cycles.
   assumes mem_req and mem_addr held until mem_ack. */
`timescale 1ns/1ps
`default_nettype none
module cfgl_mem_model (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// control
	input  wire logic       slow,
	input  wire logic [7:0] salt,
	// memory port
	input  wire logic       mem_req,
	input  wire logic [7:0] mem_addr,
	output logic [15:0]     mem_rdata,
	output logic            mem_ack
);
	logic [1:0] cnt_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= 2'h0;
			mem_ack <= 1'b0;
			mem_rdata <= 16'hFFFF;
		end else if (mem_ack) begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
		end else if (mem_req && cnt_reg == {slow, slow}) begin
			cnt_reg <= 2'h0;
			mem_ack <= 1'b1;
			mem_rdata <= {mem_addr ^ salt, (mem_addr >> 1) ^ ~salt};
		end else begin
			// data invalid outside ack
			cnt_reg <= mem_req ? cnt_reg + 2'h1 : 2'h0;
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule
`default_nettype wire

/* File: sim/cfgl_loader_chk.sv */
/* assertions on the loader top ports.
   assumes binding into cfgl_loader. */
`timescale 1ns/1ps
`default_nettype none
module cfgl_loader_chk (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr,
	// preset memory
	input  wire logic        mem_req,
	input  wire logic [7:0]  mem_addr,
	input  wire logic [15:0] mem_rdata,
	input  wire logic        mem_ack,
	// outputs
	input  wire logic [15:0] phy1_ctrl,
	input  wire logic [15:0] phy2_ctrl,
	input  wire logic [3:0]  no_soft_reset,
	input  wire logic        load_done
);
	logic [15:0] cap_reg [10];
	logic [7:0]  woff;
	assign woff = mem_addr - 8'h4C;
	// copy of every word taken
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 10; i++) begin
				cap_reg[i] <= 16'h0000;
			end
		end else if (mem_req && mem_ack) begin
			cap_reg[woff[4:1]] <= mem_rdata;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_phy1; $rose(load_done) |-> phy1_ctrl == cap_reg[1]; endproperty
	a_phy1: assert property (p_phy1) else $error("phy1 not loaded");
	property p_phy2; $rose(load_done) |-> phy2_ctrl == cap_reg[9]; endproperty
	a_phy2: assert property (p_phy2) else $error("phy2 not loaded");
	property p_nsr;
		$rose(load_done) |->
			no_soft_reset == {cap_reg[5][0], cap_reg[4][0], cap_reg[3][0], cap_reg[2][0]};
	endproperty
	a_nsr: assert property (p_nsr) else $error("soft reset flags wrong");
	property p_nsr_hold; load_done |=> $stable(no_soft_reset); endproperty
	a_nsr_hold: assert property (p_nsr_hold) else $error("flag changed");
	property p_wait; psel && penable && !load_done |-> !pready; endproperty
	a_wait: assert property (p_wait) else $error("answer before load end");
	property p_done_hold; load_done |=> load_done; endproperty
	a_done_hold: assert property (p_done_hold) else $error("load_done fell");
	property p_step;
		mem_req && mem_ack && mem_addr != 8'h5E |=> mem_addr == $past(mem_addr) + 8'h02;
	endproperty
	a_step: assert property (p_step) else $error("address step wrong");
	property p_finish;
		mem_req && mem_ack && mem_addr == 8'h5E |=> !mem_req ##[0:3] load_done;
	endproperty
	a_finish: assert property (p_finish) else $error("load not ended");
	property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
	a_err: assert property (p_err) else $error("refusal data wrong");
endmodule
bind cfgl_loader cfgl_loader_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pready(pready), .prdata(prdata), .pslverr(pslverr),
	.mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
	.phy1_ctrl(phy1_ctrl), .phy2_ctrl(phy2_ctrl), .no_soft_reset(no_soft_reset),
	.load_done(load_done));
`default_nettype wire

/* File: sim/tb_cfgl_loader.sv */
/* self-checking bench for cfgl_loader over apb.
   assumes cfgl_mem_model as the preset memory. */
`timescale 1ns/1ps
`default_nettype none
module tb_cfgl_loader;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic        mem_present, mem_req, mem_ack, load_done, slow;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [31:0] ctl_rw [4];
	logic [15:0] mem_rdata, phy1_ctrl, phy2_ctrl, e1, e2;
	logic [7:0]  mem_addr, salt;
	logic [3:0]  no_soft_reset, pstrb;
	int          n_mismatch, checks;
	cfgl_loader dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .mem_present(mem_present), .mem_req(mem_req),
		.mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
		.phy1_ctrl(phy1_ctrl), .phy2_ctrl(phy2_ctrl), .no_soft_reset(no_soft_reset),
		.load_done(load_done));
	cfgl_mem_model mem (.pclk(pclk), .presetn(presetn), .slow(slow), .salt(salt),
		.mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	function logic [15:0] wd(input logic [7:0] a);
		if (mem_present) return {a ^ salt, (a >> 1) ^ ~salt};
		if (a == 8'h4C) return 16'h2000;
		return (a >= 8'h58 && a <= 8'h5C) ? 16'h0C03 : 16'h0000;
	endfunction
	function logic [31:0] expv(input int i, input logic [7:0] o);
		logic [15:0] p;
		p = wd(8'h50 + 8'(2 * i));
		case (o)
			8'h08: return {wd(8'h58 + 8'(2 * i)), (i == 2) ? wd(8'h4C) : 16'h2000};
			8'h80: return {2'b00, p[7:6], 1'b0, p[5], p[4], p[3:1], 6'h00, 16'h0001};
			8'h84: return {p[15:8], 20'h0, p[0], 3'b000} | ctl_rw[i];
			8'hF0: return {30'h0, !mem_present, 1'b1};
			8'hA0: return {16'h0, e1};
			default: return {16'h0, e2};
		endcase
	endfunction
	task cmp(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input int i, input logic [7:0] o);
		apb(1'b0, {4'(i), o}, 32'h0);
		cmp(rdat, expv(i, o));
	endtask
	task chk_all;
		logic [31:0] v;
		for (int i = 0; i < 4; i++) begin
			if (i < 3) begin
				rd(i, 8'h08);
				rd(i, 8'hA0);
				rd(i, 8'hA4);
			end
			rd(i, 8'h80);
			rd(i, 8'h84);
			v = expv(i, 8'h84);
			cmp({31'h0, no_soft_reset[i]}, {31'h0, v[3]});
		end
		rd(0, 8'hF0);
		cmp({phy1_ctrl, phy2_ctrl}, {e1, e2});
	endtask
	task restart(input logic pres, input logic slw, input logic [7:0] s, input logic early);
		presetn <= 1'b0;
		mem_present <= pres;
		slow <= slw;
		salt <= s;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		e1 = wd(8'h4E);
		e2 = wd(8'h5E);
		ctl_rw = '{4{32'h0}};
		// read issued while still loading
		if (early) rd(0, 8'hA0);
		while (load_done !== 1'b1) @(posedge pclk);
	endtask
	task t_loaded;
		restart(1'b1, 1'b0, 8'hA5, 1'b0);
		chk_all;
	endtask
	task t_unmapped;
		apb(1'b0, 12'h010, 32'h0);
		cmp({31'h0, rerr}, 32'h1);
		cmp(rdat, 32'h0);
	endtask
	task t_writes;
		// lane 0 alone moves only the power state bits
		ctl_rw[0] = 32'h00000003;
		pstrb <= 4'h1;
		apb(1'b1, 12'h084, 32'hFFFFFFFF);
		pstrb <= 4'hF;
		rd(0, 8'h84);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, {4'(i), 8'h84}, 32'hFFFFFFFF);
			ctl_rw[i] = 32'h00000103;
			apb(1'b1, {4'(i), 8'h80}, 32'hFFFFFFFF);
			if (i < 3) apb(1'b1, {4'(i), 8'h08}, 32'hFFFFFFFF);
		end
		apb(1'b1, 12'h1A0, 32'h00001234);
		e1 = 16'h1234;
		apb(1'b1, 12'h2A4, 32'h0000ABCD);
		e2 = 16'hABCD;
		chk_all;
	endtask
	task t_slow_early;
		restart(1'b1, 1'b1, 8'h3C, 1'b1);
		chk_all;
	endtask
	task t_absent;
		restart(1'b0, 1'b0, 8'h00, 1'b1);
		chk_all;
	endtask
	task end_of_test;
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hF;
		mem_present = 1'b0;
		slow = 1'b0;
		salt = 8'h00;
		t_loaded;
		t_unmapped;
		t_writes;
		t_slow_early;
		t_absent;
		end_of_test;
	end
	initial begin
		#100000;
		n_mismatch++;
		end_of_test;
	end
endmodule
`default_nettype wire
